//--- include/field_io_pkg.sv
package field_io_pkg;

    // =======================================================================
    // Sizes
    localparam int unsigned NUM_IO        = 64;
    localparam int unsigned QUEUE_DEPTH   = 1024;
    localparam int unsigned QPTR_W        = 10;
    localparam int unsigned QCNT_W        = 11;
    localparam int unsigned ENTRY_W       = 40;
    localparam int unsigned BLOCK_MAX     = 16;

    // =======================================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned MS_PERIOD_NS  = 1000000;
    localparam int unsigned TICK_CYCLES   = MS_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned SCAN_LIMIT_NS = 100000;
    localparam int unsigned SCAN_LIMIT_CYCLES = SCAN_LIMIT_NS / CLK_PERIOD_NS;
    localparam int unsigned END_SAMPLE_NS = 10000;
    localparam int unsigned END_SAMPLE_CYCLES = END_SAMPLE_NS / CLK_PERIOD_NS;
    localparam int unsigned EDGE_LIMIT_NS = 50000;
    localparam int unsigned EDGE_LIMIT_CYCLES = EDGE_LIMIT_NS / CLK_PERIOD_NS;
    localparam logic [11:0] COMM_TIMEOUT_MS = 12'd2000;
    localparam logic [9:0]  REALIGN_MS      = 10'd999;
    localparam logic [9:0]  LS_LOSS_MS      = 10'd500;
    localparam logic [6:0]  TICK_LOSS_EVENTS = 7'd60;

    // =======================================================================
    // Reset values and encodings
    localparam logic [7:0]  FILT_DEFAULT  = 8'h05;
    localparam logic [7:0]  ROLLOVER_TAG  = 8'hff;
    localparam logic [15:0] LOW16_ONES    = 16'hffff;

    typedef enum logic {SEND_IDLE, SEND_RUN} send_state_e;

endpackage : field_io_pkg

//--- rtl/field_io_scan_filter_output.sv
`timescale 1ns/1ps
// What this block does
// - Event queue of 1024 entries, empty after reset
// - Low 16 counter bits wrap queues rollover entry
// - Rollover entry has first byte all ones
// - Send blocks on command, remove after acknowledge
// - Scan inputs 0 to 63 within 100 us
// - Sample each input once per millisecond, hold
// - Queue reported changes with number, state, timestamp
// - Same-scan changes queued by increasing input number
// - Sample counter within 10 us of scan end
// - Ignore flag suppresses change entries
// - On/off consecutive-sample filter, zero disables it
// - Reset: filter counts 5, reporting disabled
// - Outputs ON, OFF or phase wave, simultaneous
// - 2 s without host traffic, once traffic has been seen after reset, forces outputs OFF
// - Data/control bits select off, on, phase, inverted
// - Phase outputs switch within 50 us, then hold
// - Outputs never glitch; steady settings persist
// - 1 kHz reference raises one tick per millisecond
// - Rollover flag set on rollover, host clears
// - 60 phase events without tick sets counter error
// - Realign tick to rising phase edge each second
// - 500 ticks without phase event sets phase error
// - 32-bit millisecond counter increments per tick
// - Reset forces all output latches to zero
module field_io_scan_filter_output
    import field_io_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
)(
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                rst_n,
    // Field side
    input  wire logic [NUM_IO-1:0]   field_in,
    input  wire logic                line_phase,
    output logic      [NUM_IO-1:0]   field_out,
    // Input configuration
    input  wire logic                cfg_we,
    input  wire logic [5:0]          cfg_index,
    input  wire logic [7:0]          cfg_on_count,
    input  wire logic [7:0]          cfg_off_count,
    input  wire logic                cfg_ignore,
    input  wire logic                cfg_report,
    // Output setting
    input  wire logic                set_we,
    input  wire logic [NUM_IO-1:0]   set_data,
    input  wire logic [NUM_IO-1:0]   set_ctrl,
    // Host traffic and flag clears
    input  wire logic                comm_valid,
    input  wire logic                rollover_clr,
    input  wire logic                err_clr,
    // Queue block transfer
    input  wire logic                send_req,
    input  wire logic                send_ack,
    output logic                     entry_valid,
    output logic      [ENTRY_W-1:0]  entry_data,
    output logic      [QCNT_W-1:0]   queue_count,
    // Status
    output logic      [31:0]         millisecond_counter,
    output logic      [31:0]         scan_end_time,
    output logic      [NUM_IO-1:0]   sampled_in,
    output logic      [NUM_IO-1:0]   filtered_in,
    output logic                     rollover_flag,
    output logic                     comm_lost,
    output logic                     tick_error,
    output logic                     ls_error
);

    // =======================================================================
    // Millisecond reference and counter
    logic [15:0] div_q;
    logic [31:0] ms_q;
    logic [9:0]  sec_q;
    logic        realign_q;
    logic        ls_q;
    logic        ls_rise;
    logic        ls_event;
    logic        tick;
    logic        div_top;

    assign ls_rise  = line_phase & ~ls_q;
    assign ls_event = line_phase ^ ls_q;
    assign div_top  = (div_q == 16'(TICK_DIV - 1));
    assign tick     = div_top;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            div_q     <= 16'h0000;
            ms_q      <= 32'h0000_0000;
            sec_q     <= 10'h000;
            realign_q <= 1'b0;
            ls_q      <= 1'b0;
        end
        else
        begin
            ls_q <= line_phase;
            if (realign_q && ls_rise)
                div_q <= 16'h0000;
            else if (div_top)
                div_q <= 16'h0000;
            else
                div_q <= div_q + 16'h0001;
            if (tick)
                ms_q <= ms_q + 32'h0000_0001;
            if (tick)
                sec_q <= (sec_q == REALIGN_MS) ? 10'h000 : sec_q + 10'h001;
            if (tick && sec_q == REALIGN_MS)
                realign_q <= 1'b1;
            else if (ls_rise)
                realign_q <= 1'b0;
        end
    end

    // =======================================================================
    // Error monitors
    logic [6:0] ls_events_q;
    logic [9:0] ticks_q;
    logic       roll_q;
    logic       ms_err_q;
    logic       ls_err_q;
    logic       roll_set;

    assign roll_set = tick && (ms_q[15:0] == LOW16_ONES);

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ls_events_q <= 7'h00;
            ticks_q     <= 10'h000;
            roll_q      <= 1'b0;
            ms_err_q    <= 1'b0;
            ls_err_q    <= 1'b0;
        end
        else
        begin
            if (tick)
                ls_events_q <= 7'h00;
            else if (ls_event && ls_events_q != TICK_LOSS_EVENTS)
                ls_events_q <= ls_events_q + 7'h01;
            if (ls_event)
                ticks_q <= 10'h000;
            else if (tick && ticks_q != LS_LOSS_MS)
                ticks_q <= ticks_q + 10'h001;
            roll_q   <= roll_set | (roll_q & ~rollover_clr);
            ms_err_q <= (ls_events_q == TICK_LOSS_EVENTS)
                        | (ms_err_q & ~err_clr);
            ls_err_q <= (ticks_q == LS_LOSS_MS)
                        | (ls_err_q & ~err_clr);
        end
    end

    // =======================================================================
    // Input scan and filtering
    logic [7:0]        on_cnt_q  [NUM_IO];
    logic [7:0]        off_cnt_q [NUM_IO];
    logic [7:0]        run_q     [NUM_IO];
    logic [NUM_IO-1:0] ignore_q;
    logic [NUM_IO-1:0] report_q;
    logic [NUM_IO-1:0] samp_q;
    logic [NUM_IO-1:0] filt_q;
    logic              scan_q;
    logic [5:0]        idx_q;
    logic [31:0]       stamp_q;
    logic [31:0]       end_time_q;
    logic              raw_bit;
    logic              old_bit;
    logic [7:0]        limit;
    logic [8:0]        run_inc;
    logic              bypass;
    logic              accept;
    logic              new_bit;
    logic              push_tr;
    logic              scan_last;

    assign raw_bit   = field_in[idx_q];
    assign old_bit   = filt_q[idx_q];
    assign limit     = raw_bit ? on_cnt_q[idx_q] : off_cnt_q[idx_q];
    assign run_inc   = {1'b0, run_q[idx_q]} + 9'h001;
    assign bypass    = (on_cnt_q[idx_q] == 8'h00) || (off_cnt_q[idx_q] == 8'h00);
    assign accept    = (raw_bit != old_bit) && (bypass || run_inc >= {1'b0, limit});
    assign new_bit   = accept ? raw_bit : old_bit;
    assign push_tr   = scan_q && (new_bit != old_bit)
                       && report_q[idx_q] && !ignore_q[idx_q];
    assign scan_last = scan_q && (idx_q == 6'h3f);

    generate
        for (genvar i = 0; i < NUM_IO; i++)
        begin : g_input
            always_ff @(posedge mclk)
            begin
                if (!rst_n)
                begin
                    on_cnt_q[i]  <= FILT_DEFAULT;
                    off_cnt_q[i] <= FILT_DEFAULT;
                    ignore_q[i]  <= 1'b0;
                    report_q[i]  <= 1'b0;
                    run_q[i]     <= 8'h00;
                    samp_q[i]    <= 1'b0;
                    filt_q[i]    <= 1'b0;
                end
                else
                begin
                    if (cfg_we && cfg_index == 6'(i))
                    begin
                        on_cnt_q[i]  <= cfg_on_count;
                        off_cnt_q[i] <= cfg_off_count;
                        ignore_q[i]  <= cfg_ignore;
                        report_q[i]  <= cfg_report;
                    end
                    if (scan_q && idx_q == 6'(i))
                    begin
                        samp_q[i] <= raw_bit;
                        filt_q[i] <= new_bit;
                        if (raw_bit == old_bit || accept)
                            run_q[i] <= 8'h00;
                        else
                            run_q[i] <= run_inc[7:0];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            scan_q     <= 1'b0;
            idx_q      <= 6'h00;
            stamp_q    <= 32'h0000_0000;
            end_time_q <= 32'h0000_0000;
        end
        else
        begin
            if (tick)
            begin
                scan_q  <= 1'b1;
                idx_q   <= 6'h00;
                stamp_q <= ms_q;
            end
            else if (scan_last)
                scan_q <= 1'b0;
            else if (scan_q)
                idx_q <= idx_q + 6'h01;
            if (scan_last)
                end_time_q <= ms_q;
        end
    end

    // =======================================================================
    // Event queue
    logic [ENTRY_W-1:0] mem [QUEUE_DEPTH];
    logic [QPTR_W-1:0]  wr_q;
    logic [QPTR_W-1:0]  rd_q;
    logic [QCNT_W-1:0]  cnt_q;
    logic               push;
    logic               full;
    logic               push_ok;
    logic [ENTRY_W-1:0] push_word;
    logic [QCNT_W-1:0]  pop_n;
    send_state_e        st_q;
    logic [QPTR_W-1:0]  sp_q;
    logic [4:0]         left_q;
    logic [4:0]         blk_q;
    logic [4:0]         blk_take;
    logic               ev_q;
    logic [ENTRY_W-1:0] ed_q;

    assign push      = roll_set | push_tr;
    assign full      = (cnt_q == QCNT_W'(QUEUE_DEPTH));
    assign push_ok   = push && !full;
    assign push_word = roll_set ? {ROLLOVER_TAG, ms_q + 32'h0000_0001}
                                : {new_bit, 1'b0, idx_q, stamp_q};
    assign pop_n     = (send_ack && st_q == SEND_IDLE) ? QCNT_W'(blk_q) : '0;
    assign blk_take  = (cnt_q >= QCNT_W'(BLOCK_MAX)) ? 5'(BLOCK_MAX) : cnt_q[4:0];

    always_ff @(posedge mclk)
    begin
        if (push_ok)
            mem[wr_q] <= push_word;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push_ok)
                wr_q <= wr_q + QPTR_W'(1);
            rd_q  <= rd_q + pop_n[QPTR_W-1:0];
            cnt_q <= cnt_q + QCNT_W'(push_ok) - pop_n;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            st_q   <= SEND_IDLE;
            sp_q   <= '0;
            left_q <= 5'h00;
            blk_q  <= 5'h00;
            ev_q   <= 1'b0;
            ed_q   <= '0;
        end
        else
        begin
            ev_q <= 1'b0;
            unique case (st_q)
                SEND_IDLE:
                begin
                    if (send_ack)
                        blk_q <= 5'h00;
                    else if (send_req)
                    begin
                        st_q   <= SEND_RUN;
                        sp_q   <= rd_q;
                        left_q <= blk_take;
                        blk_q  <= blk_take;
                    end
                end
                SEND_RUN:
                begin
                    if (left_q == 5'h00)
                        st_q <= SEND_IDLE;
                    else
                    begin
                        ev_q   <= 1'b1;
                        ed_q   <= mem[sp_q];
                        sp_q   <= sp_q + QPTR_W'(1);
                        left_q <= left_q - 5'h01;
                    end
                end
            endcase
        end
    end

    // =======================================================================
    // Outputs and host loss timer
    logic [NUM_IO-1:0] data_q;
    logic [NUM_IO-1:0] ctrl_q;
    logic [NUM_IO-1:0] out_q;
    logic [NUM_IO-1:0] out_d;
    logic [11:0]       comm_ms_q;
    logic              lost_q;
    logic              timeout;

    assign timeout = tick && (comm_ms_q == COMM_TIMEOUT_MS - 12'd1);
    assign out_d   = (ctrl_q & ({NUM_IO{ls_q}} ^ data_q))
                     | (~ctrl_q & data_q);

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            data_q    <= '0;
            ctrl_q    <= '0;
            out_q     <= '0;
            comm_ms_q <= 12'h000;
            lost_q    <= 1'b1;
        end
        else
        begin
            if (comm_valid)
                comm_ms_q <= 12'h000;
            else if (tick && !lost_q)
                comm_ms_q <= comm_ms_q + 12'h001;
            if (timeout && !comm_valid)
            begin
                data_q <= '0;
                ctrl_q <= '0;
                lost_q <= 1'b1;
            end
            else
            begin
                if (set_we)
                begin
                    data_q <= set_data;
                    ctrl_q <= set_ctrl;
                end
                if (comm_valid)
                    lost_q <= 1'b0;
            end
            out_q <= out_d;
        end
    end

    assign field_out           = out_q;
    assign entry_valid         = ev_q;
    assign entry_data          = ed_q;
    assign queue_count         = cnt_q;
    assign millisecond_counter = ms_q;
    assign scan_end_time       = end_time_q;
    assign sampled_in          = samp_q;
    assign filtered_in         = filt_q;
    assign rollover_flag       = roll_q;
    assign comm_lost           = lost_q;
    assign tick_error          = ms_err_q;
    assign ls_error            = ls_err_q;

    // =======================================================================
    // Assertions
    logic [6:0] scan_len_q;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            scan_len_q <= 7'h00;
        else if (tick)
            scan_len_q <= 7'h00;
        else if (scan_q)
            scan_len_q <= scan_len_q + 7'h01;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_scan_span;
        $fell(scan_q) |-> scan_len_q == 7'(NUM_IO);
    endproperty
    a_scan_span: assert property (p_scan_span) else $error("scan length wrong");

    property p_ms_step;
        tick |=> ms_q == $past(ms_q) + 32'h0000_0001;
    endproperty
    a_ms_step: assert property (p_ms_step) else $error("counter not advanced");

    property p_roll_push;
        roll_set && !full |=> wr_q == $past(wr_q) + QPTR_W'(1);
    endproperty
    a_roll_push: assert property (p_roll_push) else $error("rollover not queued");

    property p_roll_flag;
        roll_set |=> roll_q;
    endproperty
    a_roll_flag: assert property (p_roll_flag) else $error("rollover flag missing");

    property p_no_overfill;
        full && !send_ack |=> cnt_q == QCNT_W'(QUEUE_DEPTH);
    endproperty
    a_no_overfill: assert property (p_no_overfill) else $error("queue overfilled");

    property p_end_time;
        scan_last |=> end_time_q == $past(ms_q);
    endproperty
    a_end_time: assert property (p_end_time) else $error("end time not sampled");

    property p_phase_follow;
        $rose(ls_q) |=> out_q == ((ctrl_q & ~data_q) | (~ctrl_q & data_q));
    endproperty
    a_phase_follow: assert property (p_phase_follow) else $error("phase output late");

    property p_timeout_off;
        timeout && !comm_valid |=> ##1 out_q == '0;
    endproperty
    a_timeout_off: assert property (p_timeout_off) else $error("outputs not off");

    property p_ignore;
        scan_q && ignore_q[idx_q] |-> !push_tr;
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignored input queued");

    c_rollover: cover property (roll_set);
    c_transition: cover property (push_tr);
    c_send: cover property (send_req ##[1:20] ev_q);
    c_timeout: cover property (timeout);

endmodule : field_io_scan_filter_output

//--- sim/host_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Host side: block polls and link activity
module host_model
    import field_io_pkg::*;
(
    // Clock
    input  wire logic               mclk,
    // Commands to the block
    output logic                    send_req,
    output logic                    send_ack,
    output logic                    comm_valid,
    // Entries from the block
    input  wire logic               entry_valid,
    input  wire logic [ENTRY_W-1:0] entry_data
);
    logic [ENTRY_W-1:0] got [BLOCK_MAX];

    initial
    begin
        send_req   = 1'b0;
        send_ack   = 1'b0;
        comm_valid = 1'b0;
    end

    // ======================================================================
    // Request a block, collect it, confirm after BLOCK_MAX + 4 + gap cycles
    task automatic poll(output int n, input int gap);
        n = 0;
        @(posedge mclk);
        send_req   <= 1'b1;
        comm_valid <= 1'b1;
        @(posedge mclk);
        send_req   <= 1'b0;
        comm_valid <= 1'b0;
        repeat (BLOCK_MAX + 4 + gap)
        begin
            @(posedge mclk);
            if (entry_valid === 1'b1 && n < BLOCK_MAX)
            begin
                got[n] = entry_data;
                n++;
            end
        end
        send_ack <= 1'b1;
        @(posedge mclk);
        send_ack <= 1'b0;
    endtask : poll
endmodule : host_model

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
    import field_io_pkg::*;
    localparam int TD = 100;

    // ======================================================================
    // Signals
    logic               mclk;
    logic               rst_n;
    logic [NUM_IO-1:0]  field_in;
    logic               line_phase;
    logic [NUM_IO-1:0]  field_out;
    logic               cfg_we;
    logic [5:0]         cfg_index;
    logic [7:0]         cfg_on_count;
    logic [7:0]         cfg_off_count;
    logic               cfg_ignore;
    logic               cfg_report;
    logic               set_we;
    logic [NUM_IO-1:0]  set_data;
    logic [NUM_IO-1:0]  set_ctrl;
    logic               comm_valid;
    logic               err_clr;
    logic               send_req;
    logic               send_ack;
    logic               entry_valid;
    logic [ENTRY_W-1:0] entry_data;
    logic [QCNT_W-1:0]  queue_count;
    logic [31:0]        millisecond_counter;
    logic [31:0]        scan_end_time;
    logic [NUM_IO-1:0]  sampled_in;
    logic [NUM_IO-1:0]  filtered_in;
    logic               rollover_flag;
    logic               comm_lost;
    logic               tick_error;
    logic               ls_error;
    logic [31:0]        t;
    int                 n;
    int                 n_mismatch;
    int                 checked;
    int                 cycles;

    // ======================================================================
    // Instances
    field_io_scan_filter_output #(.TICK_DIV(TD)) i_field_io_scan_filter_output (
        .mclk(mclk), .rst_n(rst_n), .field_in(field_in), .line_phase(line_phase),
        .field_out(field_out), .cfg_we(cfg_we), .cfg_index(cfg_index),
        .cfg_on_count(cfg_on_count), .cfg_off_count(cfg_off_count),
        .cfg_ignore(cfg_ignore), .cfg_report(cfg_report), .set_we(set_we),
        .set_data(set_data), .set_ctrl(set_ctrl), .comm_valid(comm_valid),
        .rollover_clr(1'b0), .err_clr(err_clr), .send_req(send_req), .send_ack(send_ack),
        .entry_valid(entry_valid), .entry_data(entry_data), .queue_count(queue_count),
        .millisecond_counter(millisecond_counter), .scan_end_time(scan_end_time),
        .sampled_in(sampled_in), .filtered_in(filtered_in),
        .rollover_flag(rollover_flag), .comm_lost(comm_lost), .tick_error(tick_error),
        .ls_error(ls_error));

    host_model i_host_model (
        .mclk(mclk), .send_req(send_req), .send_ack(send_ack), .comm_valid(comm_valid),
        .entry_valid(entry_valid), .entry_data(entry_data));

    // ======================================================================
    // Clock and timeout
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    // ======================================================================
    // Tasks
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic cfg_write(input logic [5:0] idx, input logic [7:0] on, input logic [7:0] off,
                             input logic ign, input logic rep);
        @(posedge mclk);
        cfg_we        <= 1'b1;
        cfg_index     <= idx;
        cfg_on_count  <= on;
        cfg_off_count <= off;
        cfg_ignore    <= ign;
        cfg_report    <= rep;
        @(posedge mclk);
        cfg_we        <= 1'b0;
    endtask : cfg_write

    task automatic set_outputs(input logic [63:0] d, input logic [63:0] c);
        @(posedge mclk);
        set_we   <= 1'b1;
        set_data <= d;
        set_ctrl <= c;
        @(posedge mclk);
        set_we   <= 1'b0;
    endtask : set_outputs

    task automatic complete_run;
        $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run

    // ======================================================================
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        field_in = '0;
        line_phase = 1'b0;
        cfg_we = 1'b0;
        cfg_index = '0;
        cfg_on_count = '0;
        cfg_off_count = '0;
        cfg_ignore = 1'b0;
        cfg_report = 1'b0;
        set_we = 1'b0;
        set_data = '0;
        set_ctrl = '0;
        err_clr = 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        check(queue_count, 64'h0);
        check(field_out, 64'h0);
        check(comm_lost, 64'h1);
        check({rollover_flag, tick_error, ls_error}, 64'h0);
        // Four output cases on every nibble
        set_outputs({16{4'ha}}, {16{4'hc}});
        repeat (3) @(posedge mclk);
        check(field_out, {16{4'ha}});
        line_phase <= 1'b1;
        repeat (3) @(posedge mclk);
        check(field_out, {16{4'h6}});
        // Scan, report, ignore, filter
        cfg_write(6'd3, 8'h00, 8'h00, 1'b0, 1'b1);
        cfg_write(6'd5, 8'h00, 8'h00, 1'b0, 1'b1);
        cfg_write(6'd10, 8'h00, 8'h00, 1'b1, 1'b1);
        field_in <= 64'h0000_0000_0000_0628;
        repeat (3 * TD) @(posedge mclk);
        check(sampled_in, 64'h0000_0000_0000_0628);
        check(filtered_in[9], 64'h0);
        check(queue_count, 64'h2);
        i_host_model.poll(n, 0);
        check(n, 64'h2);
        check(i_host_model.got[0][39:32], 64'h83);
        check(i_host_model.got[1][39:32], 64'h85);
        check(i_host_model.got[1][31:0], i_host_model.got[0][31:0]);
        repeat (2) @(posedge mclk);
        check(queue_count, 64'h0);
        check(comm_lost, 64'h0);
        repeat (8 * TD) @(posedge mclk);
        check(filtered_in[9], 64'h1);
        check(queue_count, 64'h0);
        // Counter advances once per tick
        t = millisecond_counter;
        repeat (10 * TD) @(posedge mclk);
        check(millisecond_counter, t + 32'd10);
        // Past the scan end, before the next tick
        repeat (TD / 2) @(posedge mclk);
        check(scan_end_time, t + 32'd10);
        // Falling edge entry, slow confirm
        field_in[3] <= 1'b0;
        repeat (2 * TD) @(posedge mclk);
        i_host_model.poll(n, 5);
        check(n, 64'h1);
        check(i_host_model.got[0][39:32], 64'h03);
        check(i_host_model.got[0][31:0], t + 32'd10);
        // Phase events without ticks, then clear
        repeat (2 * TD) @(posedge mclk) line_phase <= ~line_phase;
        repeat (TD) @(posedge mclk);
        check({tick_error, ls_error}, 64'h2);
        err_clr <= 1'b1;
        @(posedge mclk);
        err_clr <= 1'b0;
        repeat (2) @(posedge mclk);
        check(tick_error, 64'h0);
        check(field_out, {16{4'h6}});
        // Reset in mid-run
        rst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        check(field_out, 64'h0);
        check({queue_count, comm_lost}, 64'h1);
        complete_run();
    end
endmodule : tb
